/* rtl/spi_cs_defs.svh */
// constants for the clock-stop serial master: mode codes, strap values and timing
`ifndef SPI_CS_DEFS_SVH
`define SPI_CS_DEFS_SVH

// -----------------------------------------------------------------------------
// clock-stop mode codes
// -----------------------------------------------------------------------------
`define CS_MODE_NO_DELAY    2'h2
`define CS_MODE_HALF_DELAY  2'h3

// -----------------------------------------------------------------------------
// settings a master must carry before a word is started
// -----------------------------------------------------------------------------
`define MASTER_SYNC_POL     1'h1
`define MASTER_TX_SRC       1'h1
`define MASTER_RX_SRC       1'h0

// -----------------------------------------------------------------------------
// timing: system clock period and shortest legal bit clock cycle, in ps, and the bit clock floor in system cycles
// -----------------------------------------------------------------------------
`define CLK_PERIOD_PS       5000
`define MIN_BIT_CYCLE_PS    38500
`define MIN_BIT_SYS_CYCLES  2

// -----------------------------------------------------------------------------
// input synchroniser depth
// -----------------------------------------------------------------------------
`define RX_SYNC_STAGES      3

`endif

/* rtl/spi_cs_pkg.sv */
// shared types of the clock-stop serial master
package spi_cs_pkg;

    // -------------------------------------------------------------------------
    // word transfer sequencer states
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,  // waiting for a word
        ST_LOAD    = 3'b001,  // word arriving from the fifo
        ST_SETUP_A = 3'b010,  // select low, first bit not yet out
        ST_SETUP_B = 3'b011,  // select low, waiting for the first edge
        ST_LEAD    = 3'b100,  // clock at its active level
        ST_TRAIL   = 3'b101,  // clock back at its idle level
        ST_TAIL    = 3'b110   // data released, select about to rise
    } xfer_state_e;

endpackage : spi_cs_pkg

/* rtl/fifo_if.sv */
// carrier between the transmit fifo and the transfer sequencer
`timescale 1ns/1ps
interface fifo_if #(
    parameter int W = 8
);
    logic         push_valid;  // source offers a word
    logic         push_ready;  // fifo has room
    logic [W-1:0] push_data;   // offered word
    logic         pop_valid;   // fifo holds a word
    logic         pop_ready;   // sink takes the head word
    logic [W-1:0] pop_data;    // head word, valid the cycle after a pop

    modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
    modport user  (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface : fifo_if

/* rtl/tx_word_fifo.sv */
// transmit word fifo with registered read data
`timescale 1ns/1ps
module tx_word_fifo #(
    parameter int W     = 8,   // word width
    parameter int DEPTH = 16   // number of words
) (
    input wire logic clk,      // system clock
    input wire logic rst_n,    // asynchronous reset, active low
    fifo_if.store    f         // push and pop sides
);
    localparam int AW = $clog2(DEPTH);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;   // word storage
        logic [AW-1:0]           wp;    // write pointer
        logic [AW-1:0]           rp;    // read pointer
        logic [AW:0]             cnt;   // words held
        logic [W-1:0]            rdata; // registered head word
        logic                    room;  // push side ready
    } fifo_s;

    fifo_s q;       // registered state
    fifo_s next_q;  // next state

    logic push;     // word accepted this cycle
    logic pop;      // word taken this cycle

    assign push       = f.push_valid && q.room;
    assign pop        = f.pop_ready && (q.cnt != '0);
    assign f.push_ready = q.room;
    assign f.pop_valid  = (q.cnt != '0);
    assign f.pop_data   = q.rdata;

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb begin
        next_q = q;
        if (push) begin                       // store and advance write side
            next_q.mem[q.wp] = f.push_data;
            next_q.wp        = q.wp + AW'(1);
        end
        if (pop) begin                        // capture head and advance read side
            next_q.rdata = q.mem[q.rp];
            next_q.rp    = q.rp + AW'(1);
        end
        next_q.cnt  = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        next_q.room = (next_q.cnt != (AW+1)'(DEPTH));
    end

    // -------------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q      <= '0;
            q.room <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

endmodule : tx_word_fifo

/* rtl/serial_port_spi_master_clock_stop.sv */
// clock-stop serial master: bit clock divider, active-low select, shift in and out
`timescale 1ns/1ps
`include "spi_cs_defs.svh"
module serial_port_spi_master_clock_stop
    import spi_cs_pkg::*;
#(
    parameter int WORD_W = 8,   // bits per transfer
    parameter int DIV_W  = 8,   // width of the divider field
    parameter int DEPTH  = 16   // transmit fifo depth
) (
    input  wire logic              clk,                   // system clock, 200 MHz
    input  wire logic              rst_n,                 // asynchronous reset, active low
    input  wire logic [DIV_W-1:0]  bit_clock_divider,     // bit clock divide value
    input  wire logic [1:0]        clock_stop_mode_sel,   // clock-stop mode
    input  wire logic              tx_clock_polarity,     // bit clock idle level
    input  wire logic              tx_sync_polarity,      // must be 1 for master
    input  wire logic              rx_sync_polarity,      // must be 1 for master
    input  wire logic              tx_clock_source_sel,   // must be 1 for master
    input  wire logic              tx_sync_source_sel,    // must be 1 for master
    input  wire logic              rx_clock_source_sel,   // must be 0 for master
    input  wire logic              rx_sync_source_sel,    // must be 0 for master
    input  wire logic [WORD_W-1:0] tx_data,               // word to send
    input  wire logic              tx_valid,              // tx_data offered
    output logic                   tx_ready,              // fifo has room
    output logic [WORD_W-1:0]      rx_data,               // received word
    output logic                   rx_valid,              // one-cycle pulse with rx_data
    output logic                   busy,                  // a word is in flight
    output logic                   config_error,          // settings unfit for master
    output logic                   divider_clamped,       // divider raised to the floor
    output logic                   serial_bit_clock_out,  // bit clock pin
    output logic                   slave_select_out,      // slave select pin, active low
    output logic                   serial_tx_pin,         // transmit data pin
    output logic                   serial_tx_oe_n,        // transmit pin enable, low drives
    input  wire logic              serial_rx_pin          // receive data pin
);
    // -------------------------------------------------------------------------
    // timing derived from the clock rate
    // -------------------------------------------------------------------------
    localparam int LW          = DIV_W + 2;  // phase length width
    localparam int BW          = $clog2(WORD_W + 1);
    localparam int CYC_BY_TIME = (`MIN_BIT_CYCLE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    localparam int MIN_CYC     = (CYC_BY_TIME > `MIN_BIT_SYS_CYCLES) ? CYC_BY_TIME : `MIN_BIT_SYS_CYCLES;
    localparam int MIN_DIV     = (MIN_CYC + 1) / 2 - 1;  // period is (1+div)*2 cycles

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    typedef struct packed {
        xfer_state_e                   st;        // sequencer state
        logic [LW-1:0]                 cnt;       // cycles left in this phase
        logic [BW-1:0]                 bitn;      // bits completed
        logic [WORD_W-1:0]             txsh;      // transmit shifter
        logic [WORD_W-1:0]             rxsh;      // receive shifter
        logic                          half;      // half-cycle delay mode latched
        logic                          pol;       // clock polarity latched
        logic [LW-1:0]                 lead_len;  // cycles at active level
        logic [LW-1:0]                 trail_len; // cycles at idle level
        logic [`RX_SYNC_STAGES-1:0]    sync;      // receive pin synchroniser
        logic                          rx_bit;    // filtered receive level
        logic                          sck;       // bit clock pin
        logic                          ss_n;      // select pin
        logic                          txd;       // transmit pin
        logic                          txoe_n;    // transmit enable, low drives
        logic [WORD_W-1:0]             rx_word;   // delivered word
        logic                          rx_pulse;  // word delivered
        logic                          busy;      // word in flight
        logic                          cfg_err;   // bad master settings
        logic                          clamp;     // divider below floor
    } seq_s;

    seq_s q;       // registered state
    seq_s next_q;  // next state

    // -------------------------------------------------------------------------
    // fifo in the transmit path
    // -------------------------------------------------------------------------
    fifo_if #(.W(WORD_W)) fq ();

    tx_word_fifo #(
        .W     (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .f     (fq.store)
    );

    assign fq.push_valid = tx_valid;
    assign fq.push_data  = tx_data;
    assign tx_ready      = fq.push_ready;

    // -------------------------------------------------------------------------
    // configuration checks and phase lengths
    // -------------------------------------------------------------------------
    logic             cfg_ok;     // settings allow a master transfer
    logic             mode_ok;    // one of the two clock-stop modes
    logic [DIV_W-1:0] div_eff;    // divider after the floor
    logic             even_nz;    // divider even and not zero
    logic [LW-1:0]    lo_len;     // cycles of the low phase
    logic [LW-1:0]    hi_len;     // cycles of the high phase

    // settings a master must hold, and the divider floor
    always_comb begin
        mode_ok = (clock_stop_mode_sel == `CS_MODE_NO_DELAY) ||
                  (clock_stop_mode_sel == `CS_MODE_HALF_DELAY);
        cfg_ok  = mode_ok &&
                  (tx_sync_polarity == `MASTER_SYNC_POL) &&
                  (rx_sync_polarity == `MASTER_SYNC_POL) &&
                  (tx_clock_source_sel == `MASTER_TX_SRC) &&
                  (tx_sync_source_sel == `MASTER_TX_SRC) &&
                  (rx_clock_source_sel == `MASTER_RX_SRC) &&
                  (rx_sync_source_sel == `MASTER_RX_SRC);
        // a cycle shorter than the floor is never produced
        if (bit_clock_divider < DIV_W'(MIN_DIV)) begin
            div_eff = DIV_W'(MIN_DIV);
        end else begin
            div_eff = bit_clock_divider;
        end
        // one unit of 2P is two system cycles, so div/2 units is div cycles
        even_nz = !div_eff[0] && (div_eff != '0);
        if (even_nz) begin
            lo_len = LW'(div_eff);
            hi_len = LW'(div_eff) + LW'(2);
        end else begin
            lo_len = LW'(div_eff) + LW'(1);
            hi_len = LW'(div_eff) + LW'(1);
        end
    end

    // the sequencer only takes a word while idle and the settings are sound
    assign fq.pop_ready = (q.st == ST_IDLE) && cfg_ok;

    // -------------------------------------------------------------------------
    // edge actions
    // -------------------------------------------------------------------------
    // clock leaves its idle level
    function automatic seq_s lead_edge(input seq_s s);
        seq_s r;
        r        = s;
        r.st     = ST_LEAD;
        r.cnt    = s.lead_len - LW'(1);
        r.sck    = ~s.pol;
        if (s.half) begin
            r.rxsh = {s.rxsh[WORD_W-2:0], s.rx_bit};
        end else begin
            r.txd    = s.txsh[WORD_W-1];
            r.txsh   = s.txsh << 1;
            r.txoe_n = 1'b0;
        end
        return r;
    endfunction : lead_edge

    // clock returns to its idle level
    function automatic seq_s trail_edge(input seq_s s);
        seq_s r;
        r      = s;
        r.st   = ST_TRAIL;
        r.cnt  = s.trail_len - LW'(1);
        r.sck  = s.pol;
        r.bitn = s.bitn + BW'(1);
        if (!s.half) begin
            r.rxsh = {s.rxsh[WORD_W-2:0], s.rx_bit};
        end else if (s.bitn == BW'(WORD_W - 1)) begin
            r.txoe_n = 1'b1;
        end else begin
            r.txd  = s.txsh[WORD_W-1];
            r.txsh = s.txsh << 1;
        end
        return r;
    endfunction : trail_edge

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb begin
        next_q          = q;
        next_q.rx_pulse = 1'b0;
        next_q.cfg_err  = ~cfg_ok;
        next_q.clamp    = (bit_clock_divider < DIV_W'(MIN_DIV));
        // receive pin: three stages, a level counts once the last two agree
        next_q.sync = {q.sync[`RX_SYNC_STAGES-2:0], serial_rx_pin};
        if (q.sync[2] == q.sync[1]) begin
            next_q.rx_bit = q.sync[2];
        end
        if (q.cnt != '0) begin
            next_q.cnt = q.cnt - LW'(1);
        end
        unique case (q.st)
            ST_IDLE: begin  // clock parked, select high, data released
                next_q.sck    = tx_clock_polarity;
                next_q.ss_n   = 1'b1;
                next_q.txoe_n = 1'b1;
                next_q.busy   = 1'b0;
                if (fq.pop_ready && fq.pop_valid) begin
                    next_q.st     = ST_LOAD;
                    next_q.busy   = 1'b1;
                    next_q.half   = clock_stop_mode_sel[0];
                    next_q.pol    = tx_clock_polarity;
                    // active level is high for polarity 0, low for polarity 1
                    next_q.lead_len  = tx_clock_polarity ? lo_len : hi_len;
                    next_q.trail_len = tx_clock_polarity ? hi_len : lo_len;
                end
            end
            ST_LOAD: begin  // word arrives, select the slaves
                next_q.txsh = fq.pop_data;
                next_q.bitn = '0;
                next_q.ss_n = 1'b0;
                if (q.half) begin
                    next_q.st  = ST_SETUP_A;
                    next_q.cnt = q.lead_len - LW'(1);
                end else begin
                    next_q.st  = ST_SETUP_B;
                    next_q.cnt = q.trail_len - LW'(1);
                end
            end
            ST_SETUP_A: begin  // half delay: first bit goes out half a cycle in
                if (q.cnt == '0) begin
                    next_q.st     = ST_SETUP_B;
                    next_q.cnt    = q.trail_len - LW'(1);
                    next_q.txd    = q.txsh[WORD_W-1];
                    next_q.txsh   = q.txsh << 1;
                    next_q.txoe_n = 1'b0;
                end
            end
            ST_SETUP_B: begin  // select held low before the first edge
                if (q.cnt == '0) begin
                    next_q = lead_edge(next_q);
                end
            end
            ST_LEAD: begin  // active level, then the trailing edge
                if (q.cnt == '0) begin
                    next_q = trail_edge(next_q);
                end
            end
            ST_TRAIL: begin  // idle level, then next bit or wind-down
                if (q.cnt == '0) begin
                    if (q.bitn != BW'(WORD_W)) begin
                        next_q = lead_edge(next_q);
                    end else begin
                        next_q.rx_word  = q.rxsh;
                        next_q.rx_pulse = 1'b1;
                        if (q.half) begin
                            next_q.ss_n = 1'b1;
                            next_q.st   = ST_IDLE;
                        end else begin
                            next_q.txoe_n = 1'b1;
                            next_q.st     = ST_TAIL;
                            next_q.cnt    = q.lead_len - LW'(1);
                        end
                    end
                end
            end
            ST_TAIL: begin  // no-delay mode: select rises a full cycle after
                if (q.cnt == '0) begin
                    next_q.ss_n = 1'b1;
                    next_q.st   = ST_IDLE;
                end
            end
            default: begin  // unused code returns to idle
                next_q.st = ST_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.st     <= ST_IDLE;
            q.ss_n   <= 1'b1;
            q.txoe_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // -------------------------------------------------------------------------
    // outputs, all from the state register
    // -------------------------------------------------------------------------
    assign rx_data              = q.rx_word;
    assign rx_valid             = q.rx_pulse;
    assign busy                 = q.busy;
    assign config_error         = q.cfg_err;
    assign divider_clamped      = q.clamp;
    assign serial_bit_clock_out = q.sck;
    assign slave_select_out     = q.ss_n;
    assign serial_tx_pin        = q.txd;
    assign serial_tx_oe_n       = q.txoe_n;

endmodule : serial_port_spi_master_clock_stop

/* test/spi_cs_properties.sv */
// checker for the clock-stop serial master, bound to its top module
`timescale 1ns/1ps
module spi_cs_properties #(
    parameter int DIV_W = 8  // width of the divider field
) (
    input wire logic             clk, rst_n, busy, slave_select_out, serial_bit_clock_out,
    input wire logic             serial_tx_oe_n, rx_valid, divider_clamped, tx_clock_polarity,
    input wire logic [DIV_W-1:0] bit_clock_divider
);
    logic [7:0] d, lo, hi, cnt;  // floored divider, phase lengths, cycles since last move
    logic       prev, seen;      // last clock level, clock moved within this word
    // -------------------------------------------------------------------------
    // expected phase lengths and a run counter of the bit clock
    // -------------------------------------------------------------------------
    assign d  = (bit_clock_divider < 3) ? 8'h03 : 8'(bit_clock_divider);
    assign lo = d[0] ? d + 8'h01 : d;
    assign hi = d[0] ? d + 8'h01 : d + 8'h02;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
            seen <= 1'b0;
            cnt  <= 8'h01;
        end else begin
            prev <= serial_bit_clock_out;
            seen <= !slave_select_out && (seen || serial_bit_clock_out != prev);
            cnt  <= (slave_select_out || serial_bit_clock_out != prev) ? 8'h01 : cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_PHASE_LEN:
        assert property (!slave_select_out && seen && serial_bit_clock_out != prev
            |-> cnt == (prev ? hi : lo)) else $error("bit clock phase length wrong");
    AST_IDLE_LEVEL:
        assert property (!busy && !$past(busy) && $past(rst_n) && $stable(tx_clock_polarity)
            |-> serial_bit_clock_out == tx_clock_polarity) else $error("bit clock not at idle level");
    AST_DRIVE_SELECTED:
        assert property (!serial_tx_oe_n |-> !slave_select_out) else $error("data driven while deselected");
    AST_SELECT_AFTER_START:
        assert property ($rose(busy) |=> !slave_select_out) else $error("select late after start");
    AST_IDLE_DESELECTED:
        assert property (!busy |-> slave_select_out && serial_tx_oe_n) else $error("idle but selected");
    AST_FIRST_BIT_LATE:
        assert property ($fell(slave_select_out) |-> serial_tx_oe_n[*3]) else $error("first bit too early");
    AST_SELECT_GAP:
        assert property ($rose(slave_select_out) |-> slave_select_out[*2]) else $error("select gap short");
    AST_CLAMP_FLAG:
        assert property ($past(rst_n) |-> divider_clamped == ($past(bit_clock_divider) < 3))
            else $error("clamp flag wrong");
    AST_RX_PULSE:
        assert property (rx_valid |-> busy ##1 !rx_valid) else $error("receive pulse wrong");
    cover property ($fell(slave_select_out));
    cover property ($rose(busy) && divider_clamped);
    cover property (rx_valid && tx_clock_polarity);
endmodule : spi_cs_properties

bind serial_port_spi_master_clock_stop spi_cs_properties #(.DIV_W(DIV_W)) u_props (
    .clk(clk), .rst_n(rst_n), .busy(busy), .slave_select_out(slave_select_out),
    .serial_bit_clock_out(serial_bit_clock_out), .serial_tx_oe_n(serial_tx_oe_n), .rx_valid(rx_valid),
    .divider_clamped(divider_clamped), .tx_clock_polarity(tx_clock_polarity),
    .bit_clock_divider(bit_clock_divider));

/* test/spi_slave_model.sv */
// behavioural slave that answers the clock-stop master
`timescale 1ns/1ps
module spi_slave_model (
    input wire logic       sck,          // bit clock from the master
    input wire logic       ss_n,         // select, active low
    input wire logic       mosi,         // data from the master
    input wire logic [1:0] mode,         // clock-stop mode in use
    input wire logic       pol,          // bit clock idle level
    input wire logic [7:0] word,         // word sent back
    output logic           miso = 1'b0,  // data to the master
    output logic [7:0]     got = 8'h00   // word seen from the master
);
    int        idx;                                       // bit being presented
    bit        first;                                     // skip the leading edge once
    wire logic smp = (mode == 2'h3) ? !pol : pol;         // level the master samples on
    // load the first bit as soon as selected
    always @(negedge ss_n) begin
        idx = 7;
        first = (mode == 2'h2);
        miso = word[7];
    end
    // released line has no pull: show the inverse of the last bit in no-delay mode, the last bit itself in half-delay mode
    always @(posedge ss_n) miso = !miso;
    // capture on the sampling edge, move on the opposite one
    always @(sck) begin
        if (!ss_n && sck == smp) got = {got[6:0], mosi};
        else if (!ss_n && first) first = 1'b0;
        else if (!ss_n) begin
            idx--;
            miso = (idx >= 0) ? word[idx] : !miso;
        end
    end
endmodule : spi_slave_model

/* test/tb_top.sv */
// self-checking bench for the clock-stop serial master
`timescale 1ns/1ps
module tb_top;
    logic       clk = 1'b0, rst_n = 1'b0, tx_valid = 1'b0, pol = 1'b0;
    logic [7:0] div = 8'h03, tx_data = 8'h00, s_word = 8'h00;
    logic [1:0] mode = 2'h2;
    logic [5:0] st = 6'h3c;  // master straps, all fit
    logic       tx_ready, rx_valid, busy, cfg_err, clamped, sck, ss_n, txd, oe_n, miso;
    logic [7:0] rx_data, got;
    wire logic  mosi = oe_n ? 1'bz : txd;  // data wire, released when oe_n is high
    int         failures = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    serial_port_spi_master_clock_stop u_dut (
        .clk(clk), .rst_n(rst_n), .bit_clock_divider(div), .clock_stop_mode_sel(mode),
        .tx_clock_polarity(pol), .tx_sync_polarity(st[5]), .rx_sync_polarity(st[4]),
        .tx_clock_source_sel(st[3]), .tx_sync_source_sel(st[2]), .rx_clock_source_sel(st[1]),
        .rx_sync_source_sel(st[0]), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy), .config_error(cfg_err),
        .divider_clamped(clamped), .serial_bit_clock_out(sck), .slave_select_out(ss_n),
        .serial_tx_pin(txd), .serial_tx_oe_n(oe_n), .serial_rx_pin(miso));
    spi_slave_model u_slave (.sck(sck), .ss_n(ss_n), .mosi(mosi), .mode(mode), .pol(pol),
        .word(s_word), .miso(miso), .got(got));
    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            failures++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk
    // wait for room, offer one word for one cycle
    task automatic push(input logic [7:0] b);
        int n = 0;
        while (tx_ready !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        if (n >= 600) begin
            chk(1'b0, "no room");
            report_and_stop;
        end
        tx_data = b;
        tx_valid = 1'b1;
        @(negedge clk);
        tx_valid = 1'b0;
    endtask : push
    // wait for a word to end, compare both directions, wait for deselect
    task automatic get(input logic [7:0] exp_rx, input logic [7:0] exp_tx);
        int n = 0;
        while (rx_valid !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        chk(rx_data === exp_rx && got === exp_tx, "word differs");
        while (ss_n !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        if (n >= 600) begin
            chk(1'b0, "wait ran out");
            report_and_stop;
        end
        @(negedge clk);
    endtask : get
    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk(ss_n === 1'b1 && oe_n === 1'b1 && tx_ready === 1'b1 && sck === pol, "reset state");
        // every mode and polarity, even, odd and clamped dividers
        for (int i = 0; i < 4; i++) begin
            mode = i[1] ? 2'h3 : 2'h2;
            pol = i[0];
            div = (i == 3) ? 8'h02 : 8'h03 + 8'(i);
            s_word = 8'h3c + 8'(i);
            push(8'ha5 ^ 8'(i));
            get(8'h3c + 8'(i), 8'ha5 ^ 8'(i));
            chk(clamped === (i == 3), "clamp flag");
        end
        $display("test modes done");
        // each strap and a bad mode code in turn
        for (int b = 0; b < 7; b++) begin
            st = (b < 6) ? 6'h3c ^ (6'h01 << b) : 6'h3c;
            mode = (b < 6) ? 2'h2 : 2'h1;
            repeat (3) @(negedge clk);
            chk(cfg_err === 1'b1, "strap not flagged");
        end
        push(8'h81);
        repeat (60) @(negedge clk);
        chk(busy === 1'b0 && ss_n === 1'b1, "word started while unfit");
        mode = 2'h2;
        get(8'h3f, 8'h81);
        $display("test straps done");
        // hold words back, fill until refused, then drain back to back
        mode = 2'h0;
        for (int k = 0; k < 17; k++) begin
            tx_data = 8'(k);
            tx_valid = 1'b1;
            @(negedge clk);
        end
        tx_valid = 1'b0;
        chk(tx_ready === 1'b0, "fifo not full");
        mode = 2'h3;
        for (int k = 0; k < 16; k++) get(8'h3f, 8'(k));
        chk(tx_ready === 1'b1 && busy === 1'b0, "fifo not drained");
        $display("test fifo done");
        report_and_stop;
    end
endmodule : tb_top
